// >>> src/tsp_pkg.sv
// Shared constants and types for the transaction stream port.
package tsp_pkg;
    localparam int DATA_W = 64;
    localparam int BUF_CNT_W = 6;
    localparam int BEAT_CNT_W = 8;
    localparam int PEND_W = 4;
    // Supported maximum payload in bytes and header allowance per packet.
    localparam int MPS_BYTES = 512;
    localparam int HDR_BYTES = 16;
    localparam int BEAT_BYTES = DATA_W / 8;
    localparam int TX_MAX_BEATS = (MPS_BYTES + HDR_BYTES) / BEAT_BYTES;
    // Block memory configuration: 0 selects the small store, 1 the large one.
    localparam int TX_BRAM_CFG = 1;
    localparam int TX_MEM_SMALL = 4096;
    localparam int TX_MEM_LARGE = 8192;
    localparam int TX_MEM_BYTES = (TX_BRAM_CFG != 0) ? TX_MEM_LARGE : TX_MEM_SMALL;
    localparam int TX_BUF_RAW = TX_MEM_BYTES / (MPS_BYTES + HDR_BYTES);
    localparam int TX_BUF_MAX = 63;
    localparam int TX_BUF_TOTAL = (TX_BUF_RAW > TX_BUF_MAX) ? TX_BUF_MAX : TX_BUF_RAW;
    localparam logic [BUF_CNT_W-1:0] TX_BUF_TOTAL_V = BUF_CNT_W'(TX_BUF_TOTAL);
    localparam logic [BEAT_CNT_W-1:0] TX_MAX_BEATS_V = BEAT_CNT_W'(TX_MAX_BEATS);
    // Remainder codes on a 64-bit end-of-frame beat (active low sense).
    localparam logic REM_FULL = 1'h0;
    localparam logic REM_UPPER = 1'h1;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic sof;
        logic eof;
        logic rem;
        logic dsc;
        logic str;
        logic err;
    } tsp_beat_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_PKT = 2'b01,
        TX_DISCARD = 2'b10
    } tsp_tx_st_t;
endpackage : tsp_pkg

// >>> src/tsp_link_if.sv
// Interface joining the core end and the application end of the port.
`timescale 1ns/10ps
`default_nettype none
interface tsp_link_if;
    import tsp_pkg::*;
    logic [DATA_W-1:0] tx_packet_bus;
    logic tx_sof_n;
    logic tx_eof_n;
    logic tx_rem_n;
    logic tx_src_rdy_n;
    logic tx_dst_rdy_n;
    logic tx_discont_n;
    logic tx_streamed_n;
    logic tx_err_fwd_n;
    logic [BUF_CNT_W-1:0] tx_free_buffer_count;
    logic tx_err_drop_n;
    logic tx_cfg_req_n;
    logic tx_cfg_gnt_n;
    logic [DATA_W-1:0] rx_packet_bus;
    logic rx_sof_n;
    logic rx_eof_n;
    logic rx_rem_n;
    logic rx_src_rdy_n;
    logic rx_dst_rdy_n;

    modport core (
        input tx_packet_bus, tx_sof_n, tx_eof_n, tx_rem_n, tx_src_rdy_n,
        input tx_discont_n, tx_streamed_n, tx_err_fwd_n, tx_cfg_gnt_n, rx_dst_rdy_n,
        output tx_dst_rdy_n, tx_free_buffer_count, tx_err_drop_n, tx_cfg_req_n,
        output rx_packet_bus, rx_sof_n, rx_eof_n, rx_rem_n, rx_src_rdy_n
    );
    modport app (
        output tx_packet_bus, tx_sof_n, tx_eof_n, tx_rem_n, tx_src_rdy_n,
        output tx_discont_n, tx_streamed_n, tx_err_fwd_n, tx_cfg_gnt_n, rx_dst_rdy_n,
        input tx_dst_rdy_n, tx_free_buffer_count, tx_err_drop_n, tx_cfg_req_n,
        input rx_packet_bus, rx_sof_n, rx_eof_n, rx_rem_n, rx_src_rdy_n
    );
endinterface : tsp_link_if
`default_nettype wire

// >>> src/tsp_core_end.sv
// Core end of the transaction stream port: transmit checks and receive framing.
`timescale 1ns/10ps
`default_nettype none
module tsp_core_end
    import tsp_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic nrst,
    // Port towards the application.
    tsp_link_if.core lnk,
    // Outgoing beats towards the link.
    output logic lk_tx_valid,
    output logic [DATA_W-1:0] lk_tx_data,
    output logic lk_tx_sof,
    output logic lk_tx_eof,
    output logic lk_tx_rem,
    output logic lk_tx_go,
    output logic lk_tx_commit,
    output logic lk_tx_abort,
    output logic lk_tx_poison,
    output logic lk_int_sent,
    // Link side buffer return and internal packet posting.
    input wire logic lk_buf_release,
    input wire logic lk_int_post,
    // Incoming beats from the link.
    input wire logic lk_rx_valid,
    input wire logic [DATA_W-1:0] lk_rx_data,
    input wire logic lk_rx_sof,
    input wire logic lk_rx_eof,
    input wire logic lk_rx_upper,
    output logic lk_rx_ready
);
    typedef struct packed {
        tsp_tx_st_t st;
        logic [BEAT_CNT_W-1:0] beats;
        logic streamed;
        logic poison;
        logic [BUF_CNT_W-1:0] used;
        logic [BUF_CNT_W-1:0] free;
        logic [PEND_W-1:0] pend;
        logic req_gap;
        logic dst_rdy_n;
        logic drop_n;
        logic req_n;
        logic ltx_valid;
        logic [DATA_W-1:0] ltx_data;
        logic ltx_sof;
        logic ltx_eof;
        logic ltx_rem;
        logic ltx_go;
        logic ltx_commit;
        logic ltx_abort;
        logic ltx_poison;
        logic int_sent;
        logic rx_valid;
        logic [DATA_W-1:0] rx_data;
        logic rx_sof;
        logic rx_eof;
        logic rx_rem;
        logic rx_ready;
    } tsp_core_state_t;

    tsp_core_state_t st_reg;
    tsp_core_state_t st_next;

    always_comb begin
        logic acc;
        logic inc;
        logic dec;
        logic int_go;
        logic [BEAT_CNT_W-1:0] cnt;
        acc = 1'b0;
        inc = 1'b0;
        dec = 1'b0;
        int_go = 1'b0;
        cnt = '0;
        st_next = st_reg;
        st_next.drop_n = 1'b1;
        st_next.ltx_valid = 1'b0;
        st_next.ltx_go = 1'b0;
        st_next.ltx_commit = 1'b0;
        st_next.ltx_abort = 1'b0;
        st_next.int_sent = 1'b0;
        st_next.req_gap = 1'b0;
        acc = !lnk.tx_src_rdy_n && !st_reg.dst_rdy_n;
        cnt = st_reg.beats + 8'h01;
        unique case (st_reg.st)
            TX_IDLE: begin
                if (acc && !lnk.tx_sof_n) begin
                    st_next.beats = 8'h01;
                    st_next.streamed = !lnk.tx_streamed_n;
                    st_next.poison = !lnk.tx_err_fwd_n && lnk.tx_streamed_n;
                    st_next.ltx_valid = 1'b1;
                    st_next.ltx_sof = 1'b1;
                    st_next.ltx_eof = !lnk.tx_eof_n;
                    st_next.ltx_data = lnk.tx_packet_bus;
                    st_next.ltx_rem = lnk.tx_rem_n;
                    st_next.ltx_go = !lnk.tx_streamed_n;
                    if (!lnk.tx_eof_n) begin
                        st_next.ltx_commit = 1'b1;
                        st_next.ltx_go = 1'b1;
                        st_next.ltx_poison = !lnk.tx_err_fwd_n && lnk.tx_streamed_n;
                        inc = 1'b1;
                    end else begin
                        st_next.st = TX_PKT;
                    end
                end
            end
            TX_PKT: begin
                if (acc) begin
                    st_next.beats = cnt;
                    st_next.poison = st_reg.poison | (!lnk.tx_err_fwd_n && !st_reg.streamed);
                    if (cnt > TX_MAX_BEATS_V) begin
                        st_next.drop_n = 1'b0;
                        st_next.ltx_abort = 1'b1;
                        st_next.st = lnk.tx_eof_n ? TX_DISCARD : TX_IDLE;
                    end else begin
                        st_next.ltx_valid = 1'b1;
                        st_next.ltx_sof = 1'b0;
                        st_next.ltx_eof = !lnk.tx_eof_n;
                        st_next.ltx_data = lnk.tx_packet_bus;
                        st_next.ltx_rem = lnk.tx_eof_n ? REM_FULL : lnk.tx_rem_n;
                        if (!lnk.tx_eof_n) begin
                            st_next.st = TX_IDLE;
                            if (!lnk.tx_discont_n) begin
                                st_next.ltx_abort = 1'b1;
                            end else begin
                                st_next.ltx_commit = 1'b1;
                                st_next.ltx_go = !st_reg.streamed;
                                st_next.ltx_poison = st_next.poison;
                                inc = 1'b1;
                            end
                        end
                    end
                end else if (st_reg.streamed && !st_reg.dst_rdy_n) begin
                    st_next.drop_n = 1'b0;
                    st_next.ltx_abort = 1'b1;
                    st_next.st = TX_DISCARD;
                end
            end
            TX_DISCARD: begin
                if (acc && !lnk.tx_eof_n) begin
                    st_next.st = TX_IDLE;
                end
            end
            default: begin
                st_next.st = TX_IDLE;
            end
        endcase
        int_go = (st_reg.st == TX_IDLE) && !(acc && !lnk.tx_sof_n) && !st_reg.req_n
            && !lnk.tx_cfg_gnt_n && (st_reg.free != '0) && !inc;
        if (int_go) begin
            st_next.int_sent = 1'b1;
            st_next.req_gap = 1'b1;
            inc = 1'b1;
        end
        if (lk_int_post && !int_go && (st_reg.pend != 4'hF)) begin
            st_next.pend = st_reg.pend + 4'h1;
        end else if (int_go && !lk_int_post) begin
            st_next.pend = st_reg.pend - 4'h1;
        end
        // Request holds while no buffer frees.
        st_next.req_n = !((st_next.pend != '0) && !st_next.req_gap);
        dec = lk_buf_release && (st_reg.used != '0);
        st_next.used = st_reg.used + BUF_CNT_W'(inc) - BUF_CNT_W'(dec);
        st_next.free = TX_BUF_TOTAL_V - st_next.used;
        st_next.dst_rdy_n = (st_next.free == '0) && (st_next.st == TX_IDLE);
        // Receive holding slot; ready is registered so throughput is one beat per two cycles.
        if (st_reg.rx_valid && !lnk.rx_dst_rdy_n) begin
            st_next.rx_valid = 1'b0;
        end
        if (st_reg.rx_ready && lk_rx_valid) begin
            st_next.rx_valid = 1'b1;
            st_next.rx_data = lk_rx_data;
            st_next.rx_sof = lk_rx_sof;
            st_next.rx_eof = lk_rx_eof;
            st_next.rx_rem = (lk_rx_eof && lk_rx_upper) ? REM_UPPER : REM_FULL;
        end
        st_next.rx_ready = !st_next.rx_valid;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
            st_reg.st <= TX_IDLE;
            st_reg.free <= TX_BUF_TOTAL_V;
            st_reg.dst_rdy_n <= 1'b1;
            st_reg.drop_n <= 1'b1;
            st_reg.req_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign lnk.tx_dst_rdy_n = st_reg.dst_rdy_n;
    assign lnk.tx_free_buffer_count = st_reg.free;
    assign lnk.tx_err_drop_n = st_reg.drop_n;
    assign lnk.tx_cfg_req_n = st_reg.req_n;
    assign lnk.rx_packet_bus = st_reg.rx_data;
    assign lnk.rx_sof_n = !(st_reg.rx_valid && st_reg.rx_sof);
    assign lnk.rx_eof_n = !(st_reg.rx_valid && st_reg.rx_eof);
    assign lnk.rx_rem_n = st_reg.rx_rem;
    assign lnk.rx_src_rdy_n = !st_reg.rx_valid;
    assign lk_tx_valid = st_reg.ltx_valid;
    assign lk_tx_data = st_reg.ltx_data;
    assign lk_tx_sof = st_reg.ltx_sof;
    assign lk_tx_eof = st_reg.ltx_eof;
    assign lk_tx_rem = st_reg.ltx_rem;
    assign lk_tx_go = st_reg.ltx_go;
    assign lk_tx_commit = st_reg.ltx_commit;
    assign lk_tx_abort = st_reg.ltx_abort;
    assign lk_tx_poison = st_reg.ltx_poison;
    assign lk_int_sent = st_reg.int_sent;
    assign lk_rx_ready = st_reg.rx_ready;
endmodule : tsp_core_end
`default_nettype wire

// >>> src/tsp_app_end.sv
// Application end of the transaction stream port.
`timescale 1ns/10ps
`default_nettype none
module tsp_app_end
    import tsp_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic nrst,
    // Port towards the core.
    tsp_link_if.app lnk,
    // Transmit beats from user logic.
    input wire logic app_tx_valid,
    input wire logic [DATA_W-1:0] app_tx_data,
    input wire logic app_tx_sof,
    input wire logic app_tx_eof,
    input wire logic app_tx_upper,
    input wire logic app_tx_discont,
    input wire logic app_tx_stream,
    input wire logic app_tx_poison,
    output logic app_tx_ready,
    // Arbitration control.
    input wire logic app_cfg_hold,
    // Receive beats to user logic.
    output logic app_rx_valid,
    output logic [DATA_W-1:0] app_rx_data,
    output logic app_rx_sof,
    output logic app_rx_eof,
    output logic app_rx_upper,
    input wire logic app_rx_ready
);
    typedef struct packed {
        tsp_beat_t head;
        tsp_beat_t spare;
        logic head_v;
        logic spare_v;
        logic tx_ready;
        logic gnt_n;
        logic rdst_n;
        logic rx_valid;
        logic [DATA_W-1:0] rx_data;
        logic rx_sof;
        logic rx_eof;
        logic rx_upper;
    } tsp_app_state_t;

    tsp_app_state_t st_reg;
    tsp_app_state_t st_next;

    always_comb begin
        tsp_beat_t nb;
        logic taken;
        logic rx_acc;
        nb = '0;
        st_next = st_reg;
        nb.data = app_tx_data;
        nb.sof = app_tx_sof;
        nb.eof = app_tx_eof;
        // Remainder only on the end beat.
        nb.rem = (app_tx_eof && app_tx_upper) ? REM_UPPER : REM_FULL;
        // Discontinue only after start, with end.
        nb.dsc = app_tx_discont && app_tx_eof && !app_tx_sof;
        nb.str = app_tx_stream;
        nb.err = app_tx_poison && !app_tx_stream;
        taken = st_reg.head_v && !lnk.tx_dst_rdy_n;
        // Two-entry skid keeps a registered ready without bubbles.
        if (taken) begin
            st_next.head = st_reg.spare;
            st_next.head_v = st_reg.spare_v;
            st_next.spare_v = 1'b0;
        end
        if (app_tx_valid && st_reg.tx_ready) begin
            if (!st_next.head_v) begin
                st_next.head = nb;
                st_next.head_v = 1'b1;
            end else begin
                st_next.spare = nb;
                st_next.spare_v = 1'b1;
            end
        end
        st_next.tx_ready = !st_next.spare_v;
        // Grant withheld while user wants priority.
        st_next.gnt_n = app_cfg_hold;
        rx_acc = !lnk.rx_src_rdy_n && !st_reg.rdst_n;
        if (st_reg.rx_valid && app_rx_ready) begin
            st_next.rx_valid = 1'b0;
        end
        if (rx_acc) begin
            st_next.rx_valid = 1'b1;
            st_next.rx_data = lnk.rx_packet_bus;
            st_next.rx_sof = !lnk.rx_sof_n;
            st_next.rx_eof = !lnk.rx_eof_n;
            st_next.rx_upper = !lnk.rx_eof_n && (lnk.rx_rem_n == REM_UPPER);
        end
        st_next.rdst_n = st_next.rx_valid;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
            st_reg.gnt_n <= 1'b1;
            st_reg.rdst_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign lnk.tx_packet_bus = st_reg.head.data;
    assign lnk.tx_sof_n = !(st_reg.head_v && st_reg.head.sof);
    assign lnk.tx_eof_n = !(st_reg.head_v && st_reg.head.eof);
    assign lnk.tx_rem_n = st_reg.head.rem;
    assign lnk.tx_src_rdy_n = !st_reg.head_v;
    assign lnk.tx_discont_n = !(st_reg.head_v && st_reg.head.dsc);
    assign lnk.tx_streamed_n = !(st_reg.head_v && st_reg.head.str);
    // Poison any beat of a non-streamed frame.
    assign lnk.tx_err_fwd_n = !(st_reg.head_v && st_reg.head.err);
    assign lnk.tx_cfg_gnt_n = st_reg.gnt_n;
    assign lnk.rx_dst_rdy_n = st_reg.rdst_n;
    assign app_tx_ready = st_reg.tx_ready;
    assign app_rx_valid = st_reg.rx_valid;
    assign app_rx_data = st_reg.rx_data;
    assign app_rx_sof = st_reg.rx_sof;
    assign app_rx_eof = st_reg.rx_eof;
    assign app_rx_upper = st_reg.rx_upper;
endmodule : tsp_app_end
`default_nettype wire

// >>> testbench/tsp_link_checker.sv
// Concurrent checks on the signals that join the two ends of the stream port.
`timescale 1ns/10ps
`default_nettype none
module tsp_link_checker
    import tsp_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic nrst,
    // Transmit signals.
    input wire logic tx_sof_n,
    input wire logic tx_eof_n,
    input wire logic tx_src_rdy_n,
    input wire logic tx_dst_rdy_n,
    input wire logic tx_streamed_n,
    input wire logic [BUF_CNT_W-1:0] tx_free_buffer_count,
    input wire logic tx_err_drop_n,
    input wire logic tx_cfg_req_n,
    input wire logic tx_cfg_gnt_n,
    // Receive signals.
    input wire logic [DATA_W-1:0] rx_packet_bus,
    input wire logic rx_sof_n,
    input wire logic rx_eof_n,
    input wire logic rx_rem_n,
    input wire logic rx_src_rdy_n,
    input wire logic rx_dst_rdy_n
);
    logic str_pkt_reg;
    logic str_pkt_next;
    logic tx_take;

    assign tx_take = !tx_src_rdy_n && !tx_dst_rdy_n;

    // A streamed packet is followed from its first beat until it ends or stalls once.
    always_comb begin
        str_pkt_next = str_pkt_reg;
        if (tx_take && !tx_eof_n)
            str_pkt_next = 1'b0;
        else if (tx_take && !tx_sof_n)
            str_pkt_next = !tx_streamed_n;
        else if (tx_src_rdy_n && !tx_dst_rdy_n)
            str_pkt_next = 1'b0;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            str_pkt_reg <= 1'b0;
        else
            str_pkt_reg <= str_pkt_next;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_gnt_nobuf;
        !tx_cfg_req_n && !tx_cfg_gnt_n && tx_free_buffer_count == '0;
    endsequence
    sequence s_rx_wait;
        !rx_src_rdy_n && rx_dst_rdy_n;
    endsequence
    sequence s_rx_hold;
        !rx_src_rdy_n && $stable(rx_packet_bus) && $stable({rx_sof_n, rx_eof_n, rx_rem_n});
    endsequence

    AST_FREE_MAX: assert property (tx_free_buffer_count <= TX_BUF_TOTAL_V)
        else $error("free buffer count above total");
    AST_FREE_RESET: assert property ($rose(nrst) |-> tx_free_buffer_count == TX_BUF_TOTAL_V)
        else $error("free buffer count wrong after reset");
    AST_DST_FULL: assert property (tx_dst_rdy_n && $past(nrst) |-> tx_free_buffer_count == '0)
        else $error("core not ready while buffers free");
    AST_DROP_ONE: assert property (!tx_err_drop_n |=> tx_err_drop_n)
        else $error("drop indication longer than one cycle");
    AST_DROP_CAUSE: assert property ($fell(tx_err_drop_n) |-> $past(!tx_dst_rdy_n))
        else $error("drop without a beat slot");
    AST_GAP_DROP: assert property (str_pkt_reg && tx_src_rdy_n && !tx_dst_rdy_n |=> !tx_err_drop_n)
        else $error("streamed gap not dropped");
    AST_REQ_NOBUF: assert property (s_gnt_nobuf |=> !tx_cfg_req_n)
        else $error("request dropped without buffers");
    AST_REQ_GRANT: assert property ($rose(tx_cfg_req_n) |-> $past(!tx_cfg_gnt_n))
        else $error("request withdrawn without grant");
    AST_RX_HOLD: assert property (s_rx_wait |=> s_rx_hold)
        else $error("receive beat changed before taken");
    AST_RX_NEXT: assert property (!rx_src_rdy_n && !rx_dst_rdy_n |=> rx_src_rdy_n)
        else $error("receive beat repeated after taken");
endmodule : tsp_link_checker
`default_nettype wire

// >>> testbench/tlp_transaction_stream_port_bench.sv
// Self-checking bench that joins the core end and the application end.
`timescale 1ns/10ps
`default_nettype none
module tlp_transaction_stream_port_bench;
    import tsp_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [DATA_W-1:0] app_tx_data, app_rx_data, lk_tx_data, lk_rx_data;
    logic app_tx_valid, app_tx_sof, app_tx_eof, app_tx_upper, app_tx_discont, app_tx_stream;
    logic app_tx_poison, app_tx_ready, app_cfg_hold, app_rx_valid, app_rx_sof, app_rx_eof;
    logic app_rx_upper, app_rx_ready, lk_tx_valid, lk_tx_sof, lk_tx_eof, lk_tx_rem, lk_tx_go;
    logic lk_tx_commit, lk_tx_abort, lk_tx_poison, lk_int_sent, lk_buf_release, lk_int_post;
    logic lk_rx_valid, lk_rx_sof, lk_rx_eof, lk_rx_upper, lk_rx_ready;
    int mismatches = 0;
    int checked = 0;
    int cyc = 0;
    int drops = 0;
    int sents = 0;
    int exp_free;
    bit dchk = 1'b1;
    logic [67:0] txq[$];
    logic [66:0] rxq[$];
    logic [2:0] evq[$];

    tsp_link_if lnk ();
    tsp_core_end u_tsp_core_end (.lnk(lnk), .*);
    tsp_app_end u_tsp_app_end (.lnk(lnk), .*);
    tsp_link_checker u_tsp_link_checker (.mclk(mclk), .nrst(nrst), .tx_sof_n(lnk.tx_sof_n),
        .tx_eof_n(lnk.tx_eof_n), .tx_src_rdy_n(lnk.tx_src_rdy_n),
        .tx_dst_rdy_n(lnk.tx_dst_rdy_n), .tx_streamed_n(lnk.tx_streamed_n),
        .tx_free_buffer_count(lnk.tx_free_buffer_count), .tx_err_drop_n(lnk.tx_err_drop_n),
        .tx_cfg_req_n(lnk.tx_cfg_req_n), .tx_cfg_gnt_n(lnk.tx_cfg_gnt_n),
        .rx_packet_bus(lnk.rx_packet_bus), .rx_sof_n(lnk.rx_sof_n), .rx_eof_n(lnk.rx_eof_n),
        .rx_rem_n(lnk.rx_rem_n), .rx_src_rdy_n(lnk.rx_src_rdy_n),
        .rx_dst_rdy_n(lnk.rx_dst_rdy_n));

    always #25 mclk = ~mclk;

    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    task automatic chk(input bit ok, input string m);
        checked++;
        if (!ok) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask : tick

    task automatic beat(input logic [DATA_W-1:0] d, input logic s, e, u, x, t, p);
        int k;
        {app_tx_valid, app_tx_data, app_tx_sof, app_tx_eof} = {1'b1, d, s, e};
        {app_tx_upper, app_tx_discont, app_tx_stream, app_tx_poison} = {u, x, t, p};
        // Grant toggles freely here; nothing is pending while user beats flow.
        app_cfg_hold = 1'($urandom);
        // Start pulse: at the first beat when streamed or single, else at a stored end.
        if (dchk)
            txq.push_back({s ? t | e : e & !t, s, e, u & e, d});
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (app_tx_ready !== 1'b1 && k < 100);
        #2;
    endtask : beat

    // One idle cycle is put before beat g when g is above zero; streamed packets must not gap.
    task automatic pkt(input int n, input bit t, p, x, input int g);
        for (int i = 0; i < n; i++) begin
            if (i == g && g > 0) begin
                app_tx_valid = 1'b0;
                tick(1);
            end
            // Discontinue away from the end beat must be ignored.
            beat({$urandom, $urandom}, i == 0, i == n - 1, 1'($urandom),
                i == n - 1 ? x : 1'($urandom), t, p && i == n - 1);
        end
    endtask : pkt

    task automatic rx(input logic [DATA_W-1:0] d, input logic s, e, u);
        int k;
        {lk_rx_valid, lk_rx_data, lk_rx_sof, lk_rx_eof, lk_rx_upper} = {1'b1, d, s, e, u};
        rxq.push_back({s, e, u & e, d});
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (lk_rx_ready !== 1'b1 && k < 100);
        #2;
    endtask : rx

    task automatic rel(input int n);
        lk_buf_release = 1'b1;
        tick(n);
        lk_buf_release = 1'b0;
        exp_free += n;
    endtask : rel

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            $display("[FAIL] %0t run did not finish", $time);
            conclude();
        end
    end

    always @(posedge mclk) if (nrst) #2 app_rx_ready = ($urandom % 3) != 0;

    // Outputs are watched on the falling edge, where every register has settled.
    always @(negedge mclk) if (nrst) begin
        if (lnk.tx_err_drop_n === 1'b0)
            drops++;
        if (lk_int_sent === 1'b1)
            sents++;
        if (lk_tx_valid === 1'b1 && dchk) begin
            if (txq.size() == 0)
                chk(1'b0, "tx beat without note");
            else
                chk({lk_tx_go, lk_tx_sof, lk_tx_eof, lk_tx_rem & lk_tx_eof, lk_tx_data} ===
                    txq.pop_front(), "tx beat");
        end
        if (lk_tx_commit === 1'b1 || lk_tx_abort === 1'b1) begin
            if (evq.size() == 0)
                chk(1'b0, "packet end without note");
            else
                chk({lk_tx_abort, lk_tx_poison, lk_tx_go} === evq.pop_front(), "packet end");
        end
        if (app_rx_valid === 1'b1 && app_rx_ready === 1'b1) begin
            if (rxq.size() == 0)
                chk(1'b0, "rx beat without note");
            else
                chk({app_rx_sof, app_rx_eof, app_rx_upper & app_rx_eof, app_rx_data} ===
                    rxq.pop_front(), "rx beat");
        end
    end

    initial begin
        {app_tx_valid, app_tx_data, app_tx_sof, app_tx_eof, app_tx_upper} = '0;
        {app_tx_discont, app_tx_stream, app_tx_poison, app_cfg_hold, app_rx_ready} = '0;
        {lk_buf_release, lk_int_post, lk_rx_valid, lk_rx_data, lk_rx_sof} = '0;
        {lk_rx_eof, lk_rx_upper} = '0;
        void'($urandom(94537));
        exp_free = TX_BUF_TOTAL;
        repeat (20) @(posedge mclk);
        chk(lnk.tx_free_buffer_count === TX_BUF_TOTAL_V && lnk.tx_err_drop_n === 1'b1,
            "reset values");
        #2 nrst = 1'b1;
        tick(2);
        evq.push_back(3'b011);
        pkt(4, 1'b0, 1'b1, 1'b0, 0);
        evq.push_back(3'b001);
        pkt(1, 1'b0, 1'b0, 1'b0, 0);
        evq.push_back(3'b000);
        pkt(3, 1'b1, 1'b0, 1'b0, 0);
        evq.push_back(3'b000);
        pkt(2, 1'b1, 1'b1, 1'b0, 0);
        app_tx_valid = 1'b0;
        tick(12);
        exp_free -= 4;
        chk(lnk.tx_free_buffer_count === 6'(exp_free), "free after packets");
        rel(4);
        $display("test good packets done");
        dchk = 1'b0;
        evq.push_back(3'b100);
        pkt(67, 1'b0, 1'b0, 1'b0, 0);
        evq.push_back(3'b100);
        pkt(3, 1'b0, 1'b0, 1'b1, 0);
        evq.push_back(3'b100);
        pkt(4, 1'b1, 1'b0, 1'b0, 2);
        app_tx_valid = 1'b0;
        tick(20);
        chk(drops == 2 && evq.size() == 0, "drops");
        chk(lnk.tx_free_buffer_count === 6'(exp_free), "free after drops");
        dchk = 1'b1;
        $display("test faults done");
        app_cfg_hold = 1'b1;
        lk_int_post = 1'b1;
        tick(1);
        lk_int_post = 1'b0;
        tick(10);
        chk(lnk.tx_cfg_req_n === 1'b0 && sents == 0, "request waits for grant");
        app_cfg_hold = 1'b0;
        tick(6);
        chk(sents == 1 && lnk.tx_cfg_req_n === 1'b1, "one internal packet");
        exp_free--;
        repeat (exp_free) begin
            evq.push_back(3'b001);
            pkt(1, 1'b0, 1'b0, 1'b0, 0);
        end
        app_tx_valid = 1'b0;
        tick(10);
        exp_free = 0;
        app_cfg_hold = 1'b0;
        chk(lnk.tx_free_buffer_count === '0 && lnk.tx_dst_rdy_n === 1'b1, "buffers full");
        lk_int_post = 1'b1;
        tick(1);
        lk_int_post = 1'b0;
        tick(10);
        chk(lnk.tx_cfg_req_n === 1'b0 && sents == 1, "request kept without buffers");
        rel(1);
        tick(6);
        exp_free--;
        chk(sents == 2, "internal packet after release");
        rel(TX_BUF_TOTAL);
        tick(3);
        chk(lnk.tx_free_buffer_count === TX_BUF_TOTAL_V, "all buffers back");
        $display("test arbitration done");
        for (int i = 0; i < 12; i++)
            rx({$urandom, $urandom}, i % 4 == 0, i % 4 == 3, 1'($urandom));
        lk_rx_valid = 1'b0;
        tick(40);
        chk(rxq.size() == 0 && txq.size() == 0, "queues drained");
        $display("test receive done");
        conclude();
    end
endmodule : tlp_transaction_stream_port_bench
`default_nettype wire
